// ==== design/dsr_core.sv ====
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// (R1) Align to the sync signal edge itself
// (R2) Any input selectable as sync, rate coded; the rate field is stored but nothing reads it
// (R3) Associated clock integer multiple, up to 1GHz
// (R4) Rising sync edge aligns; bit selects falling
// (R5) Four operating modes from mode field
// (R6) Reset enters free-run
// (R7) Free-run to lock-acquire on qualified selection
// (R8) Lock-acquire back to free-run when none qualified
// (R9) Acquire or recover to locked on lock
// (R10) Locked to holdover when none qualified
// (R11) Holdover or switch in lock enters recover
// (R12) Recover back to holdover when none qualified
// (R13) Switch on loss, revertive gain, forced selection
// (R14) Free-run ignores all references
// (R15) Holdover steers from stored offset, simple/advanced
// (R16) Two stores while locked, 0-63s interval
// (R17) Forced holdover ignores valid references
// (R18) Manual holdover uses software offset value
// (R19) Four-bit reference selection mode per loop
// (R20) Highest priority enabled valid input chosen
// (R21) Manual selection ignores monitors, invalid holds over
// (R22) Slave modes use designated input only
// (R23) Disqualify pin invalidates its input
// (R24) Lock flag qualified over configurable cycles
// (R25) Forced free-run and locked freeze state
module dsr_core
  import dsr_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int LOCK_LEN = LOCK_QUAL_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Monitor verdicts and loop feedback, same clock
  input wire logic [NUM_INPUTS-1:0] ref_valid,
  input wire logic lock_flag,
  input wire logic [FREQ_W-1:0] freq_offset,
  // Pins from outside
  input wire logic [NUM_INPUTS-1:0] disqualify_pin,
  input wire logic [IDX_W-1:0] select_pin,
  input wire logic slave_pin,
  input wire logic [NUM_INPUTS-1:0] sync_pin,
  // Loop control outputs
  output logic [2:0] loop_state,
  output logic [IDX_W-1:0] selected_input,
  output logic track_ref,
  output logic [FREQ_W-1:0] holdover_word,
  output logic holdover_load,
  output logic align_pulse
);
  dsr_state_type state; // Loop state
  dsr_state_type next_state;
  logic [CTRL_W-1:0] ctrl; // Control register
  logic [NUM_INPUTS-1:0] input_en; // Input enables
  logic [15:0] priority_tbl; // input_priority_table, lower is better
  logic [SEL_W-1:0] select_reg; // Manual and slave input choice
  logic [HOLD_INT_W-1:0] hold_interval; // Seconds between stores
  logic [FREQ_W-1:0] manual_hold; // Software holdover value
  logic [FREQ_W-1:0] hold_old; // Older stored offset
  logic [FREQ_W-1:0] hold_new; // Newer stored offset
  logic [FREQ_W-1:0] snap; // Offset just before holdover
  logic [NUM_INPUTS-1:0] dq_s; // Synchronised disqualify pins
  logic [IDX_W-1:0] sel_pin_s;
  logic slave_pin_s;
  logic [NUM_INPUTS-1:0] sync_s;
  logic [1:0] op_mode;
  logic [3:0] reference_selection_mode;
  logic [NUM_INPUTS-1:0] usable; // Monitor valid and not pin-disqualified
  logic [NUM_INPUTS-1:0] qualified; // Usable and enabled
  logic best_any;
  logic [IDX_W-1:0] best_idx;
  logic [PRI_W-1:0] best_pri;
  logic [IDX_W-1:0] target; // Input the selector wants
  logic avail; // Target is usable
  logic cur_ok; // Current input usable
  logic switch_req; // Move to another input
  logic [$clog2(LOCK_LEN+1)-1:0] lock_cnt;
  logic lock_ok; // Qualified lock indication
  logic [$clog2(TICK_LEN)-1:0] tick_cnt;
  logic tick; // One-second enable
  logic [HOLD_INT_W-1:0] sec_cnt;
  logic enter_hold;
  logic sync_lvl;
  logic sync_prev;
  logic ap_write; // Pending write data phase
  logic [7:0] ap_addr;

  assign op_mode = ctrl[CTRL_OP_LSB +: 2];
  assign reference_selection_mode = ctrl[CTRL_REFMODE_LSB +: 4];

  // Pin synchronisers for every outside level
  dsr_sync3 #(.W(2*NUM_INPUTS + IDX_W + 1)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin({disqualify_pin, select_pin, slave_pin, sync_pin}),
    .level({dq_s, sel_pin_s, slave_pin_s, sync_s})
  );

  // Qualification per input
  assign usable = ref_valid & ~dq_s; // [R23]
  assign qualified = usable & input_en; // [R20]

  // Best qualified input by priority; ties keep lowest index
  always_comb begin
    best_any = 1'b0;
    best_idx = '0;
    best_pri = '1;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (qualified[i] && (!best_any || priority_tbl[i*PRI_W +: PRI_W] < best_pri)) begin // [R20]
        best_any = 1'b1;
        best_idx = IDX_W'(i);
        best_pri = priority_tbl[i*PRI_W +: PRI_W];
      end
    end
  end

  // Target input per reference selection mode
  always_comb begin
    target = selected_input;
    avail = 1'b0;
    cur_ok = usable[selected_input];
    case (reference_selection_mode) // [R19]
      REF_MANUAL: begin
        // Monitors do not steer the choice, only validity
        target = select_reg[SEL_MANUAL_LSB +: IDX_W]; // [R21]
        avail = usable[target];
      end
      REF_PIN: begin
        target = sel_pin_s; // [R21]
        avail = usable[target];
      end
      REF_SLAVE: begin
        target = select_reg[SEL_SLAVE_LSB +: IDX_W]; // [R22]
        avail = usable[target];
      end
      REF_AUTO, REF_PIN_SLAVE: begin
        if (reference_selection_mode == REF_PIN_SLAVE && slave_pin_s) begin
          target = select_reg[SEL_SLAVE_LSB +: IDX_W]; // [R22]
          avail = usable[target];
        end else begin
          cur_ok = qualified[selected_input];
          avail = best_any;
          // No current input in free-run or holdover, so choose afresh by priority
          if (!cur_ok || state == ST_FREERUN || state == ST_HOLDOVER) begin
            target = best_idx; // [R13]
          end else if (ctrl[CTRL_REVERT] &&
                       best_pri < priority_tbl[selected_input*PRI_W +: PRI_W]) begin
            target = best_idx; // [R13]
          end
        end
      end
      default: begin
        // Reserved codes keep the present input
        avail = cur_ok;
      end
    endcase
  end

  assign switch_req = avail && (target != selected_input); // [R13]

  // Lock flag must hold for LOCK_LEN cycles to count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_cnt <= '0;
    end else if (!lock_flag || switch_req) begin
      lock_cnt <= '0;
    end else if (lock_cnt != ($clog2(LOCK_LEN+1))'(LOCK_LEN)) begin
      lock_cnt <= lock_cnt + 1'b1; // [R24]
    end
  end
  assign lock_ok = (lock_cnt == ($clog2(LOCK_LEN+1))'(LOCK_LEN)); // [R24]

  // Next state: forced modes first, then automatic graph
  always_comb begin
    next_state = state;
    if (ctrl[CTRL_MAN_HOLD]) begin
      next_state = ST_HOLDOVER; // [R18]
    end else if (op_mode == OP_FORCE_LOCK) begin
      next_state = ST_LOCKED; // [R25] [R5]
    end else if (op_mode == OP_FORCE_FREE) begin
      next_state = ST_FREERUN; // [R25] [R5]
    end else if (op_mode == OP_FORCE_HOLD) begin
      next_state = ST_HOLDOVER; // [R17] [R5]
    end else begin
      case (state)
        ST_FREERUN: begin
          if (avail) next_state = ST_LOCK_ACQUIRE; // [R7]
        end
        ST_LOCK_ACQUIRE: begin
          if (!cur_ok && !avail) next_state = ST_FREERUN; // [R8]
          else if (cur_ok && lock_ok && !switch_req) next_state = ST_LOCKED; // [R9]
        end
        ST_LOCKED: begin
          if (!cur_ok && !avail) next_state = ST_HOLDOVER; // [R10]
          else if (switch_req) next_state = ST_LOCK_RECOVER; // [R11]
        end
        ST_HOLDOVER: begin
          if (avail) next_state = ST_LOCK_RECOVER; // [R11]
        end
        ST_LOCK_RECOVER: begin
          if (!cur_ok && !avail) next_state = ST_HOLDOVER; // [R12]
          else if (cur_ok && lock_ok && !switch_req) next_state = ST_LOCKED; // [R9]
        end
        default: next_state = ST_FREERUN;
      endcase
    end
  end

  // State register and its mirrored outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ST_FREERUN; // [R6]
      loop_state <= 3'h0;
      track_ref <= 1'b0;
    end else begin
      state <= next_state;
      loop_state <= 3'(next_state);
      // Free-run and holdover take nothing from references
      track_ref <= (next_state == ST_LOCK_ACQUIRE) || (next_state == ST_LOCKED) ||
                   (next_state == ST_LOCK_RECOVER); // [R14]
    end
  end

  // Selected input follows the selector
  always_ff @(posedge clk) begin
    if (!nrst) begin
      selected_input <= '0;
    end else if (switch_req) begin
      selected_input <= target; // [R13]
    end
  end

  // One-second tick divider
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == ($clog2(TICK_LEN))'(TICK_LEN - 1));
      if (tick_cnt == ($clog2(TICK_LEN))'(TICK_LEN - 1)) tick_cnt <= '0;
      else tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // Advanced store pair, shifted while locked
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sec_cnt <= '0;
      hold_old <= '0;
      hold_new <= '0;
    end else if (state != ST_LOCKED || hold_interval == '0) begin
      // Interval zero halts storing
      sec_cnt <= '0;
    end else if (tick) begin
      if (sec_cnt + 1'b1 >= hold_interval) begin
        sec_cnt <= '0;
        hold_old <= hold_new; // [R16]
        hold_new <= freq_offset; // [R16]
      end else begin
        sec_cnt <= sec_cnt + 1'b1;
      end
    end
  end

  // Simple snapshot tracks offset until holdover starts
  always_ff @(posedge clk) begin
    if (!nrst) begin
      snap <= '0;
    end else if (state == ST_LOCKED || state == ST_LOCK_RECOVER) begin
      snap <= freq_offset; // [R15]
    end
  end

  assign enter_hold = (next_state == ST_HOLDOVER) && (state != ST_HOLDOVER);

  // Holdover word and integrator load strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      holdover_word <= '0;
      holdover_load <= 1'b0;
    end else begin
      holdover_load <= enter_hold;
      if (ctrl[CTRL_MAN_HOLD]) begin
        holdover_word <= manual_hold; // [R18]
      end else if (enter_hold) begin
        holdover_word <= ctrl[CTRL_ADV_HOLD] ? hold_old : snap; // [R15] [R16]
      end
    end
  end

  // Sync edge of the input named by the sync source field, not of its clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_lvl <= 1'b0;
      sync_prev <= 1'b0;
      align_pulse <= 1'b0;
    end else begin
      sync_lvl <= sync_s[ctrl[CTRL_SYNC_SRC_LSB +: IDX_W]]; // [R2] [R1]
      sync_prev <= sync_lvl;
      align_pulse <= ctrl[CTRL_SYNC_EN] &&
                     (ctrl[CTRL_SYNC_FALL] ? (sync_prev && !sync_lvl)
                                           : (!sync_prev && sync_lvl)); // [R4]
    end
  end

  // Bus address phase capture and zero-wait answer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ap_write <= 1'b0;
      ap_addr <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_write <= hsel && hready && htrans[1] && hwrite;
      ap_addr <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        if (haddr[7:0] == OFS_CTRL) hrdata <= 32'(ctrl);
        else if (haddr[7:0] == OFS_INPUT_EN) hrdata <= 32'(input_en);
        else if (haddr[7:0] == OFS_PRIORITY) hrdata <= 32'(priority_tbl);
        else if (haddr[7:0] == OFS_SELECT) hrdata <= 32'(select_reg);
        else if (haddr[7:0] == OFS_HOLD_INTERVAL) hrdata <= 32'(hold_interval);
        else if (haddr[7:0] == OFS_MANUAL_HOLD) hrdata <= 32'(manual_hold);
        else if (haddr[7:0] == OFS_STATUS) begin
          hrdata <= 32'({qualified, selected_input, 3'(state)});
        end
        else if (haddr[7:0] == OFS_HOLD_OLD) hrdata <= 32'(hold_old);
        else if (haddr[7:0] == OFS_HOLD_NEW) hrdata <= 32'(hold_new);
        else if (haddr[7:0] == OFS_HOLD_WORD) hrdata <= 32'(holdover_word);
        else hrdata <= 32'h00000000;
      end
    end
  end

  // Register writes in the data phase; hsize is whole words only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      input_en <= INPUT_EN_RESET;
      priority_tbl <= PRIORITY_RESET;
      select_reg <= SELECT_RESET;
      hold_interval <= HOLD_INT_RESET;
      manual_hold <= '0;
    end else if (ap_write) begin
      if (ap_addr == OFS_CTRL) ctrl <= hwdata[CTRL_W-1:0];
      else if (ap_addr == OFS_INPUT_EN) input_en <= hwdata[NUM_INPUTS-1:0];
      else if (ap_addr == OFS_PRIORITY) priority_tbl <= hwdata[15:0];
      else if (ap_addr == OFS_SELECT) select_reg <= hwdata[SEL_W-1:0];
      else if (ap_addr == OFS_HOLD_INTERVAL) hold_interval <= hwdata[HOLD_INT_W-1:0];
      else if (ap_addr == OFS_MANUAL_HOLD) manual_hold <= hwdata[FREQ_W-1:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_auto;
    op_mode == OP_AUTO && !ctrl[CTRL_MAN_HOLD];
  endsequence
  sequence s_lost;
    !cur_ok && !avail;
  endsequence
  sequence s_enter_hold;
    state != ST_HOLDOVER ##1 state == ST_HOLDOVER;
  endsequence

  a_reset_free: assert property ($rose(nrst) |-> state == ST_FREERUN) // [R6]
    else $error("state not free-run after reset");
  a_acq_entry: assert property (s_auto and (state == ST_FREERUN && avail)
    |=> state == ST_LOCK_ACQUIRE) else $error("no lock-acquire entry"); // [R7]
  a_acq_drop: assert property (s_auto and (state == ST_LOCK_ACQUIRE) and s_lost
    |=> state == ST_FREERUN) else $error("lock-acquire kept without input"); // [R8]
  a_lock_loss: assert property (s_auto and (state == ST_LOCKED) and s_lost
    |=> state == ST_HOLDOVER) else $error("locked kept without input"); // [R10]
  a_rec_drop: assert property (s_auto and (state == ST_LOCK_RECOVER) and s_lost
    |=> state == ST_HOLDOVER) else $error("recover kept without input"); // [R12]
  a_forced_hold: assert property (op_mode == OP_FORCE_HOLD ##1 op_mode == OP_FORCE_HOLD
    |-> state == ST_HOLDOVER && !track_ref) else $error("forced holdover left"); // [R17]
  a_forced_free: assert property ((op_mode == OP_FORCE_FREE && !ctrl[CTRL_MAN_HOLD]) // [R25]
    ##1 op_mode == OP_FORCE_FREE |-> state == ST_FREERUN && loop_state == 3'h0)
    else $error("free-run not forced");
  a_hold_load: assert property (s_enter_hold |-> holdover_load)
    else $error("no holdover load on entry"); // [R15]
  a_manual_hold: assert property (ctrl[CTRL_MAN_HOLD] |=> state == ST_HOLDOVER
    ##1 holdover_word == $past(manual_hold)) else $error("manual holdover wrong"); // [R18]
  a_sync_edge: assert property (ctrl[CTRL_SYNC_EN] && !ctrl[CTRL_SYNC_FALL]
    && $rose(sync_lvl) |=> align_pulse) else $error("rising sync edge missed"); // [R4]
  a_free_track: assert property (state == ST_FREERUN |-> !track_ref)
    else $error("free-run tracks a reference"); // [R14]
endmodule : dsr_core

// ==== design/dsr_sync3.sv ====
`timescale 1ns/10ps
// Three-stage pin synchroniser with agreement filter
module dsr_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1; // Metastability catcher, read only by s2
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Shift chain
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change only once two late stages agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end
endmodule : dsr_sync3

// ==== shared/dsr_pkg.sv ====
package dsr_pkg;
  // Reference inputs per loop and their index width
  localparam int NUM_INPUTS = 4;
  localparam int IDX_W = 2;
  localparam int PRI_W = 4;
  // Clock and one-second tick
  localparam int CLK_PERIOD_NS = 100;
  localparam longint SECOND_NS = 64'd1000000000;
  localparam int TICK_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam int LOCK_QUAL_CYCLES = 16;
  localparam int FREQ_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INPUT_EN = 8'h04;
  localparam logic [7:0] OFS_PRIORITY = 8'h08;
  localparam logic [7:0] OFS_SELECT = 8'h0C;
  localparam logic [7:0] OFS_HOLD_INTERVAL = 8'h10;
  localparam logic [7:0] OFS_MANUAL_HOLD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_HOLD_OLD = 8'h1C;
  localparam logic [7:0] OFS_HOLD_NEW = 8'h20;
  localparam logic [7:0] OFS_HOLD_WORD = 8'h24;
  // Control register field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_REFMODE_LSB = 2;
  localparam int CTRL_REVERT = 6;
  localparam int CTRL_SYNC_FALL = 7;
  localparam int CTRL_SYNC_EN = 8;
  localparam int CTRL_ADV_HOLD = 9;
  localparam int CTRL_MAN_HOLD = 10;
  localparam int CTRL_SYNC_SRC_LSB = 11;
  localparam int CTRL_SYNC_RATE_LSB = 13;
  localparam int CTRL_W = 17;
  // Select register field positions
  localparam int SEL_MANUAL_LSB = 0;
  localparam int SEL_SLAVE_LSB = 2;
  localparam int SEL_W = 4;
  localparam int HOLD_INT_W = 6;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 17'h00000;
  localparam logic [NUM_INPUTS-1:0] INPUT_EN_RESET = 4'hF;
  localparam logic [15:0] PRIORITY_RESET = 16'h3210;
  localparam logic [SEL_W-1:0] SELECT_RESET = 4'h0;
  localparam logic [HOLD_INT_W-1:0] HOLD_INT_RESET = 6'h01;
  // Operating mode field
  localparam logic [1:0] OP_AUTO = 2'h0;
  localparam logic [1:0] OP_FORCE_LOCK = 2'h1;
  localparam logic [1:0] OP_FORCE_FREE = 2'h2;
  localparam logic [1:0] OP_FORCE_HOLD = 2'h3;
  // Reference selection mode field
  localparam logic [3:0] REF_AUTO = 4'h0;
  localparam logic [3:0] REF_MANUAL = 4'h1;
  localparam logic [3:0] REF_PIN = 4'h2;
  localparam logic [3:0] REF_SLAVE = 4'h3;
  localparam logic [3:0] REF_PIN_SLAVE = 4'h4;
  // Loop operating states
  typedef enum logic [2:0] {
    ST_FREERUN, ST_LOCK_ACQUIRE, ST_LOCKED, ST_HOLDOVER, ST_LOCK_RECOVER
  } dsr_state_type;
endpackage : dsr_pkg

// ==== tb/dsr_core_bench.sv ====
`timescale 1ns/10ps
module dsr_core_bench
  import dsr_pkg::*;
;
  // Short second and short lock count keep the run brief
  localparam int TICK = 20;
  logic clk, nrst, hsel, hwrite, lock_cmd, slave_pin, hreadyout, hresp;
  logic lock_flag, track_ref, holdover_load, align_pulse;
  logic [31:0] haddr, hwdata, hrdata, freq_offset, holdover_word, o, n;
  logic [1:0] htrans, select_pin, selected_input;
  logic [2:0] hsize, loop_state;
  logic [3:0] valid_cmd, ref_valid, disqualify_pin, sync_pin;
  int miscompares, tests_run;
  // Design under test
  dsr_core #(.TICK_LEN(TICK), .LOCK_LEN(4)) dut_u (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ref_valid(ref_valid), .lock_flag(lock_flag), .freq_offset(freq_offset),
    .disqualify_pin(disqualify_pin), .select_pin(select_pin), .slave_pin(slave_pin),
    .sync_pin(sync_pin), .loop_state(loop_state), .selected_input(selected_input),
    .track_ref(track_ref), .holdover_word(holdover_word), .holdover_load(holdover_load),
    .align_pulse(align_pulse));
  // Monitors and detector stand-in
  dsr_ref_model ref_u (.clk(clk), .nrst(nrst), .valid_cmd(valid_cmd), .lock_cmd(lock_cmd),
    .track_ref(track_ref), .ref_valid(ref_valid), .lock_flag(lock_flag),
    .freq_offset(freq_offset));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Reset also clears every pin, so scenarios start clean
  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    valid_cmd <= 4'h0;
    lock_cmd <= 1'b0;
    disqualify_pin <= 4'h0;
    select_pin <= 2'h0;
    slave_pin <= 1'b0;
    sync_pin <= 4'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
  endtask : do_reset
  // One AHB single transfer; waits on hready, no fixed latency
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask : rchk
  task automatic drive(input logic [3:0] v, input logic l);
    @(posedge clk);
    valid_cmd <= v;
    lock_cmd <= l;
  endtask : drive
  // Bounded wait on state (sel=0) or selected input (sel=1)
  task automatic wait_for(input bit sel, input logic [2:0] v);
    int k = 0;
    while (((sel ? {1'b0, selected_input} : loop_state) !== v) && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    check({29'h0, sel ? {1'b0, selected_input} : loop_state}, {29'h0, v});
  endtask : wait_for
  task automatic t_regs;
    do_reset();
    wait_for(0, ST_FREERUN);
    check({31'h0, track_ref}, 32'h0);
    rchk(OFS_CTRL, 32'h0);
    check({31'h0, hresp}, 32'h0);
    rchk(OFS_INPUT_EN, 32'hF);
    rchk(OFS_PRIORITY, 32'h3210);
    rchk(OFS_SELECT, 32'h0);
    rchk(OFS_HOLD_INTERVAL, 32'h1);
    rchk(8'h3C, 32'h0);
  endtask : t_regs
  // Walk every edge of the automatic state machine
  task automatic t_auto;
    do_reset();
    drive(4'h2, 1'b0);
    wait_for(0, ST_LOCK_ACQUIRE);
    drive(4'h4, 1'b0);
    wait_for(1, 3'h2);
    check({29'h0, loop_state}, {29'h0, ST_LOCK_ACQUIRE});
    drive(4'h0, 1'b0);
    wait_for(0, ST_FREERUN);
    drive(4'h6, 1'b0);
    wait_for(1, 3'h1);
    drive(4'h6, 1'b1);
    wait_for(0, ST_LOCKED);
    drive(4'h0, 1'b0);
    wait_for(0, ST_HOLDOVER);
    drive(4'h2, 1'b0);
    wait_for(0, ST_LOCK_RECOVER);
    drive(4'h0, 1'b0);
    wait_for(0, ST_HOLDOVER);
    drive(4'h2, 1'b1);
    wait_for(0, ST_LOCKED);
    wreg(OFS_CTRL, 32'h40);
    drive(4'h7, 1'b0);
    wait_for(1, 3'h0);
    wait_for(0, ST_LOCK_RECOVER);
    @(posedge clk);
    disqualify_pin <= 4'h1;
    wait_for(1, 3'h1);
    check({29'h0, loop_state}, {29'h0, ST_LOCK_RECOVER});
  endtask : t_auto
  // Forced modes hold the state despite valid references
  task automatic t_ops;
    logic [2:0] st [4] = '{ST_FREERUN, ST_LOCKED, ST_FREERUN, ST_HOLDOVER};
    do_reset();
    drive(4'hF, 1'b0);
    wait_for(0, ST_LOCK_ACQUIRE);
    for (int i = 1; i < 4; i++) begin
      wreg(OFS_CTRL, {30'h0, 2'(i)});
      wait_for(0, st[i]);
      repeat (20) @(posedge clk);
      check({29'h0, loop_state}, {29'h0, st[i]});
    end
    wreg(OFS_MANUAL_HOLD, 32'hA5A51234);
    wreg(OFS_CTRL, 32'h400);
    wait_for(0, ST_HOLDOVER);
    repeat (3) @(posedge clk);
    check(holdover_word, 32'hA5A51234);
  endtask : t_ops
  // Manual, pin, slave, pin-slave and reserved selection
  task automatic t_refs;
    do_reset();
    drive(4'hF, 1'b0);
    wreg(OFS_SELECT, 32'h6);
    wreg(OFS_CTRL, 32'h4);
    wait_for(1, 3'h2);
    drive(4'hF, 1'b1);
    wait_for(0, ST_LOCKED);
    drive(4'hB, 1'b0);
    wait_for(0, ST_HOLDOVER);
    select_pin <= 2'h3;
    wreg(OFS_CTRL, 32'h8);
    drive(4'hF, 1'b0);
    wait_for(1, 3'h3);
    wreg(OFS_CTRL, 32'hC);
    wait_for(1, 3'h1);
    wreg(OFS_CTRL, 32'h4);
    wait_for(1, 3'h2);
    wreg(OFS_CTRL, 32'h10);
    slave_pin <= 1'b1;
    wait_for(1, 3'h1);
    wreg(OFS_CTRL, 32'h14);
    repeat (10) @(posedge clk);
    check({30'h0, selected_input}, 32'h1);
  endtask : t_refs
  // One sync pin level step; counts alignment pulses after it
  task automatic sync_leg(input logic [3:0] lvl, input int exp);
    int c = 0;
    @(posedge clk);
    sync_pin <= lvl;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (align_pulse === 1'b1) c++;
    end
    check(32'(c), 32'(exp));
  endtask : sync_leg
  task automatic t_sync;
    do_reset();
    for (int f = 0; f < 2; f++) begin
      wreg(OFS_CTRL, 32'h00002900 | (32'(f) << 7));
      sync_leg(4'h1, 0);
      sync_leg(4'h0, 0);
      sync_leg(4'h2, 1 - f);
      sync_leg(4'h0, f);
    end
  endtask : t_sync
  // Two stores one interval apart; entry restores the older
  task automatic t_adv;
    do_reset();
    wreg(OFS_CTRL, 32'h200);
    drive(4'h1, 1'b1);
    wait_for(0, ST_LOCKED);
    repeat (100) @(posedge clk);
    wreg(OFS_HOLD_INTERVAL, 32'h0);
    ahb(1'b0, OFS_HOLD_OLD, 32'h0, o);
    ahb(1'b0, OFS_HOLD_NEW, 32'h0, n);
    check(n - o, 32'(TICK) * 32'h101);
    drive(4'h0, 1'b0);
    wait_for(0, ST_HOLDOVER);
    check({31'h0, holdover_load}, 32'h1);
    repeat (2) @(posedge clk);
    check(holdover_word, o);
  endtask : t_adv
  // Watchdog well above the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  // Main sequence
  initial begin
    miscompares = 0;
    tests_run = 0;
    {nrst, hsel, hwrite, lock_cmd, slave_pin} = 5'h00;
    {haddr, hwdata, htrans, select_pin} = '0;
    {valid_cmd, disqualify_pin, sync_pin} = '0;
    hsize = 3'h2;
    t_regs();
    t_auto();
    t_ops();
    t_refs();
    t_sync();
    t_adv();
    end_of_test();
  end
endmodule : dsr_core_bench

// ==== tb/dsr_ref_model.sv ====
`timescale 1ns/10ps
// Far side: reference monitors, phase detector and loop filter
module dsr_ref_model
  import dsr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [NUM_INPUTS-1:0] valid_cmd,
  input wire logic lock_cmd,
  input wire logic track_ref,
  output logic [NUM_INPUTS-1:0] ref_valid,
  output logic lock_flag,
  output logic [FREQ_W-1:0] freq_offset
);
  // Verdicts follow commands a cycle late, like a real monitor
  always_ff @(posedge clk) begin
    ref_valid <= nrst ? valid_cmd : 4'h0;
    // Detector can only lock while the loop tracks
    lock_flag <= nrst & lock_cmd & track_ref;
  end
  // Offset drifts every cycle so a stale copy is visible
  always_ff @(posedge clk) begin
    freq_offset <= nrst ? freq_offset + 32'h00000101 : 32'h00000000;
  end
endmodule : dsr_ref_model
